// *** include/srsi_consts.svh ***
// Offsets, field positions, reset values and encodings of the rate and request block
`ifndef SRSI_CONSTS_SVH
`define SRSI_CONSTS_SVH

// Register byte offsets, one aligned 32-bit word each
`define SRSI_OFS_RELOAD     8'h00
`define SRSI_OFS_TX_SRC     8'h04
`define SRSI_OFS_RX_SRC     8'h08
`define SRSI_OFS_MODE1      8'h0c
`define SRSI_OFS_REQ_STAT   8'h10
`define SRSI_OFS_REQ_EN     8'h14
`define SRSI_OFS_TXEV_STAT  8'h18
`define SRSI_OFS_TXEV_EN    8'h1c
`define SRSI_OFS_RXEV_STAT  8'h20
`define SRSI_OFS_RXEV_EN    8'h24

// Request status and enable bit positions
`define SRSI_BIT_TX_EVENT   7
`define SRSI_BIT_RX_EVENT   6
`define SRSI_BIT_TX_SPACE   1
`define SRSI_BIT_RX_DATA    0
`define SRSI_REQ_MASK       8'hc3

// Mode register one fields
`define SRSI_RATIO_LSB      6
`define SRSI_MODE_ASYNC     2'h0
`define SRSI_MODE_BYTE      2'h1
`define SRSI_MODE_BIT       2'h2
`define SRSI_RATIO_1        2'h0
`define SRSI_RATIO_16       2'h1
`define SRSI_RATIO_32       2'h2
`define SRSI_RATIO_64       2'h3

// Divider limits and reload behaviour
`define SRSI_EXP_MAX        4'h9
`define SRSI_RELOAD_ZERO    9'h100
`define SRSI_TX_SRC_N       3
`define SRSI_RX_SRC_N       12

// Reset values
`define SRSI_RST_RELOAD     8'h00
`define SRSI_RST_EXP        4'h0
`define SRSI_RST_MODE       2'h0
`define SRSI_RST_RATIO      2'h0

// Bus responses
`define SRSI_RESP_OKAY      2'h0
`define SRSI_RESP_SLVERR    2'h2

`endif

// *** include/srsi_pkg.sv ***
// Types shared by the rate and request block
package srsi_pkg;

  // Register selected by a bus address
  typedef enum logic [3:0] {
    SEL_RELOAD,
    SEL_TX_SRC,
    SEL_RX_SRC,
    SEL_MODE1,
    SEL_REQ_STAT,
    SEL_REQ_EN,
    SEL_TXEV_STAT,
    SEL_TXEV_EN,
    SEL_RXEV_STAT,
    SEL_RXEV_EN,
    SEL_NONE
  } srsi_reg_type;

endpackage : srsi_pkg

// *** include/srsi_rate_if.sv ***
// Settings and clock enables passed between the register side and the rate generator
interface srsi_rate_if;
  logic [7:0]      reload_period;  // Reload time constant, zero means 256
  logic [1:0][3:0] exponent;       // Divider exponents, index 0 transmit, 1 receive
  logic [1:0]      ratio;          // Asynchronous clock ratio code
  logic            async_mode;     // High in asynchronous mode
  logic [1:0]      clk_en;         // Sampling clock enables, one-cycle pulses
  logic [1:0]      bit_en;         // Bit rate enables, one-cycle pulses

  modport ctrl (
    output reload_period,
    output exponent,
    output ratio,
    output async_mode,
    input  clk_en,
    input  bit_en
  );

  modport gen (
    input  reload_period,
    input  exponent,
    input  ratio,
    input  async_mode,
    output clk_en,
    output bit_en
  );
endinterface : srsi_rate_if

// *** logic/srsi_rate_gen.sv ***
// Reload timer with per-direction power-of-two dividers and asynchronous ratio stage
`include "srsi_consts.svh"

module srsi_rate_gen (
  input wire logic aclk,
  input wire logic aresetn,
  srsi_rate_if.gen rate
);

  // Mask of low counter bits for a divide by two to the exponent, clamped at nine
  function automatic logic [8:0] exp_mask(input logic [3:0] e);
    if (e >= `SRSI_EXP_MAX) begin
      exp_mask = 9'h1ff;
    end else begin
      exp_mask = 9'((9'h001 << e) - 9'h001);
    end
  endfunction : exp_mask

  // Mask for the asynchronous ratio stage; sync modes bypass it
  function automatic logic [5:0] ratio_mask(input logic [1:0] r, input logic async_on);
    if (!async_on) begin
      ratio_mask = 6'h00;
    end else begin
      case (r)
        `SRSI_RATIO_16: ratio_mask = 6'h0f;
        `SRSI_RATIO_32: ratio_mask = 6'h1f;
        `SRSI_RATIO_64: ratio_mask = 6'h3f;
        default:        ratio_mask = 6'h00;
      endcase
    end
  endfunction : ratio_mask

  logic [8:0] reload_count;  // Down counter of system clocks
  logic       reload_tick;   // One-cycle pulse per reload period

  // Zero reloads as 256
  wire [8:0] reload_load = (rate.reload_period == 8'h00) ? `SRSI_RELOAD_ZERO
                                                         : {1'b0, rate.reload_period};
  wire       reload_hit  = (reload_count == 9'h001);

  // Reload timer; a new constant takes effect at the next reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_count <= `SRSI_RELOAD_ZERO;
      reload_tick  <= 1'b0;
    end else begin
      reload_tick  <= reload_hit;
      reload_count <= reload_hit ? reload_load : 9'(reload_count - 9'h001);
    end
  end

  // One divider chain per direction, both fed by the same tick stream
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dir
      logic [8:0] div_count;    // Counts reload ticks
      logic [5:0] ratio_count;  // Counts divider outputs
      logic       clk_q;        // Sampling clock enable
      logic       bit_q;        // Bit rate enable

      wire [8:0] dmask   = exp_mask(rate.exponent[d]);
      wire [5:0] rmask   = ratio_mask(rate.ratio, rate.async_mode);
      wire       div_hit = reload_tick && ((div_count & dmask) == dmask);
      wire       bit_hit = div_hit && ((ratio_count & rmask) == rmask);

      // Counters advance only on their enabling pulse
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          div_count   <= 9'h000;
          ratio_count <= 6'h00;
          clk_q       <= 1'b0;
          bit_q       <= 1'b0;
        end else begin
          clk_q <= div_hit;
          bit_q <= bit_hit;
          if (reload_tick) begin
            div_count <= 9'(div_count + 9'h001);
          end
          if (div_hit) begin
            ratio_count <= 6'(ratio_count + 6'h01);
          end
        end
      end

      assign rate.clk_en[d] = clk_q;
      assign rate.bit_en[d] = bit_q;
    end
  endgenerate

endmodule : srsi_rate_gen

// *** logic/srsi_top.sv ***
// Serial channel rate selection and request logic with an AXI4-Lite register slave
`include "srsi_consts.svh"

module srsi_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire logic        tx_space_ready,
  input  wire logic        rx_data_ready,
  input  wire logic [2:0]  tx_source_event,
  input  wire logic [11:0] rx_source_event,
  output wire logic        tx_clk_en,
  output wire logic        rx_clk_en,
  output wire logic        tx_bit_en,
  output wire logic        rx_bit_en,
  output      logic        tx_space_request,
  output      logic        rx_data_request,
  output      logic        tx_event_request,
  output      logic        rx_event_request,
  output      logic        irq
);

  // Address decode shared by the read and write paths
  function automatic srsi_pkg::srsi_reg_type reg_sel(input logic [7:0] a);
    case (a)
      `SRSI_OFS_RELOAD:    reg_sel = srsi_pkg::SEL_RELOAD;
      `SRSI_OFS_TX_SRC:    reg_sel = srsi_pkg::SEL_TX_SRC;
      `SRSI_OFS_RX_SRC:    reg_sel = srsi_pkg::SEL_RX_SRC;
      `SRSI_OFS_MODE1:     reg_sel = srsi_pkg::SEL_MODE1;
      `SRSI_OFS_REQ_STAT:  reg_sel = srsi_pkg::SEL_REQ_STAT;
      `SRSI_OFS_REQ_EN:    reg_sel = srsi_pkg::SEL_REQ_EN;
      `SRSI_OFS_TXEV_STAT: reg_sel = srsi_pkg::SEL_TXEV_STAT;
      `SRSI_OFS_TXEV_EN:   reg_sel = srsi_pkg::SEL_TXEV_EN;
      `SRSI_OFS_RXEV_STAT: reg_sel = srsi_pkg::SEL_RXEV_STAT;
      `SRSI_OFS_RXEV_EN:   reg_sel = srsi_pkg::SEL_RXEV_EN;
      default:             reg_sel = srsi_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // Software-visible settings
  logic [7:0]  reload_period;        // Reload time constant
  logic [3:0]  tx_divider_exponent;  // Transmit divider exponent
  logic [3:0]  rx_divider_exponent;  // Receive divider exponent
  logic [1:0]  protocol_mode;        // Async, byte sync or bit sync
  logic [1:0]  async_clock_ratio;    // Async sampling ratio code
  logic [7:0]  request_enable_reg;   // Top-level request enables
  logic [2:0]  tx_source_status;     // Sticky transmit event sources
  logic [2:0]  tx_source_enable;     // Transmit source enables
  logic [11:0] rx_source_status;     // Sticky receive event sources
  logic [11:0] rx_source_enable;     // Receive source enables

  // Write channel holding state
  logic        aw_held;  // Write address accepted, waiting for data
  logic [7:0]  aw_addr;  // Held write address
  logic        w_held;   // Write data accepted, waiting for address
  logic [31:0] w_data;   // Held write data
  logic [3:0]  w_strb;   // Held byte enables

  // Rate generator link
  srsi_rate_if rate_link ();

  // Slave handshakes; one write and one read in flight at most
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  wire aw_fire = awvalid && awready;
  wire w_fire  = wvalid && wready;
  wire ar_fire = arvalid && arready;
  wire wr_fire = aw_held && w_held && !bvalid;

  // Write decode and byte lanes
  srsi_pkg::srsi_reg_type wr_sel;
  srsi_pkg::srsi_reg_type rd_sel;
  assign wr_sel = reg_sel(aw_addr);
  assign rd_sel = reg_sel(araddr);

  wire lane0 = wr_fire && w_strb[0];
  wire lane1 = wr_fire && w_strb[1];
  wire wr_map = (wr_sel != srsi_pkg::SEL_NONE);

  // Write-one-to-clear masks for the sticky source bits
  wire [2:0]  tx_clear = (lane0 && wr_sel == srsi_pkg::SEL_TXEV_STAT) ? w_data[2:0] : 3'h0;
  wire [7:0]  rx_clr_lo = (lane0 && wr_sel == srsi_pkg::SEL_RXEV_STAT) ? w_data[7:0] : 8'h00;
  wire [3:0]  rx_clr_hi = (lane1 && wr_sel == srsi_pkg::SEL_RXEV_STAT) ? w_data[11:8] : 4'h0;
  wire [11:0] rx_clear  = {rx_clr_hi, rx_clr_lo};

  // New events win over a clear in the same cycle
  wire [2:0]  next_tx_source_status = (tx_source_status & ~tx_clear) | tx_source_event;
  wire [11:0] next_rx_source_status = (rx_source_status & ~rx_clear) | rx_source_event;

  // Per-source gating and event summaries
  wire tx_event_pending = |(tx_source_status & tx_source_enable);
  wire rx_event_pending = |(rx_source_status & rx_source_enable);

  // Summary status does not look at the top-level enables
  logic [7:0] request_status_reg;
  always_comb begin
    request_status_reg = 8'h00;
    request_status_reg[`SRSI_BIT_TX_EVENT] = tx_event_pending;
    request_status_reg[`SRSI_BIT_RX_EVENT] = rx_event_pending;
    request_status_reg[`SRSI_BIT_TX_SPACE] = tx_space_ready;
    request_status_reg[`SRSI_BIT_RX_DATA]  = rx_data_ready;
  end

  // Enabled requests
  wire [7:0] next_request = request_status_reg & request_enable_reg & `SRSI_REQ_MASK;

  // Read data selection
  wire [31:0] rd_word =
    (rd_sel == srsi_pkg::SEL_RELOAD)    ? {24'h000000, reload_period} :
    (rd_sel == srsi_pkg::SEL_TX_SRC)    ? {28'h0000000, tx_divider_exponent} :
    (rd_sel == srsi_pkg::SEL_RX_SRC)    ? {28'h0000000, rx_divider_exponent} :
    (rd_sel == srsi_pkg::SEL_MODE1)     ? {24'h000000, async_clock_ratio, 4'h0, protocol_mode} :
    (rd_sel == srsi_pkg::SEL_REQ_STAT)  ? {24'h000000, request_status_reg} :
    (rd_sel == srsi_pkg::SEL_REQ_EN)    ? {24'h000000, request_enable_reg} :
    (rd_sel == srsi_pkg::SEL_TXEV_STAT) ? {29'h00000000, tx_source_status} :
    (rd_sel == srsi_pkg::SEL_TXEV_EN)   ? {29'h00000000, tx_source_enable} :
    (rd_sel == srsi_pkg::SEL_RXEV_STAT) ? {20'h00000, rx_source_status} :
    (rd_sel == srsi_pkg::SEL_RXEV_EN)   ? {20'h00000, rx_source_enable} :
                                          32'h00000000;

  // Address and data may arrive in either order; each is parked until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, raised the cycle after the write lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `SRSI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_map ? `SRSI_RESP_OKAY : `SRSI_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read response; data is captured with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `SRSI_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= (rd_sel != srsi_pkg::SEL_NONE) ? `SRSI_RESP_OKAY : `SRSI_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Rate settings; written from byte lane zero only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_period       <= `SRSI_RST_RELOAD;
      tx_divider_exponent <= `SRSI_RST_EXP;
      rx_divider_exponent <= `SRSI_RST_EXP;
      protocol_mode       <= `SRSI_RST_MODE;
      async_clock_ratio   <= `SRSI_RST_RATIO;
    end else if (lane0) begin
      if (wr_sel == srsi_pkg::SEL_RELOAD) begin
        reload_period <= w_data[7:0];
      end
      if (wr_sel == srsi_pkg::SEL_TX_SRC) begin
        tx_divider_exponent <= w_data[3:0];
      end
      if (wr_sel == srsi_pkg::SEL_RX_SRC) begin
        rx_divider_exponent <= w_data[3:0];
      end
      if (wr_sel == srsi_pkg::SEL_MODE1) begin
        protocol_mode     <= w_data[1:0];
        async_clock_ratio <= w_data[`SRSI_RATIO_LSB +: 2];
      end
    end
  end

  // Enables; reserved request enable bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_enable_reg <= 8'h00;
      tx_source_enable   <= 3'h0;
      rx_source_enable   <= 12'h000;
    end else begin
      if (lane0 && wr_sel == srsi_pkg::SEL_REQ_EN) begin
        request_enable_reg <= w_data[7:0] & `SRSI_REQ_MASK;
      end
      if (lane0 && wr_sel == srsi_pkg::SEL_TXEV_EN) begin
        tx_source_enable <= w_data[2:0];
      end
      if (lane0 && wr_sel == srsi_pkg::SEL_RXEV_EN) begin
        rx_source_enable[7:0] <= w_data[7:0];
      end
      if (lane1 && wr_sel == srsi_pkg::SEL_RXEV_EN) begin
        rx_source_enable[11:8] <= w_data[11:8];
      end
    end
  end

  // Sticky source status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_source_status <= 3'h0;
      rx_source_status <= 12'h000;
    end else begin
      tx_source_status <= next_tx_source_status;
      rx_source_status <= next_rx_source_status;
    end
  end

  // Registered request lines and the combined interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_space_request <= 1'b0;
      rx_data_request  <= 1'b0;
      tx_event_request <= 1'b0;
      rx_event_request <= 1'b0;
      irq              <= 1'b0;
    end else begin
      tx_space_request <= next_request[`SRSI_BIT_TX_SPACE];
      rx_data_request  <= next_request[`SRSI_BIT_RX_DATA];
      tx_event_request <= next_request[`SRSI_BIT_TX_EVENT];
      rx_event_request <= next_request[`SRSI_BIT_RX_EVENT];
      irq              <= |next_request;
    end
  end

  // Settings to the generator; any mode but async skips the ratio stage
  assign rate_link.reload_period = reload_period;
  assign rate_link.exponent[0]   = tx_divider_exponent;
  assign rate_link.exponent[1]   = rx_divider_exponent;
  assign rate_link.ratio         = async_clock_ratio;
  assign rate_link.async_mode    = (protocol_mode == `SRSI_MODE_ASYNC);

  // Shared reload timer and both dividers
  srsi_rate_gen u_rate_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rate    (rate_link)
  );

  // Clock enables towards transmitter and receiver
  assign tx_clk_en = rate_link.clk_en[0];
  assign rx_clk_en = rate_link.clk_en[1];
  assign tx_bit_en = rate_link.bit_en[0];
  assign rx_bit_en = rate_link.bit_en[1];

endmodule : srsi_top

// *** verification/srsi_top_properties.sv ***
// Port-level checks of the rate and request block
module srsi_top_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        tx_space_ready,
  input wire logic        rx_data_ready,
  input wire logic        tx_space_request,
  input wire logic        rx_data_request,
  input wire logic        tx_event_request,
  input wire logic        rx_event_request,
  input wire logic        irq
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Interrupt line is the summary of all four requests
  chk_irq_summary: assert property (irq == (tx_space_request | rx_data_request
    | tx_event_request | rx_event_request))
    else $error("irq differs from request summary");
  // Level requests only after their live input was high
  chk_space_follow: assert property (tx_space_request |-> $past(tx_space_ready))
    else $error("space request without space");
  chk_data_follow: assert property (rx_data_request |-> $past(rx_data_ready))
    else $error("data request without data");
  // Bus answers with the latency given in the hand-over
  // Both channels are parked one edge, so the response shows two edges after the take
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  // Responses stand until taken
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped or changed");
  chk_bresp_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  // One transfer at a time
  chk_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  chk_read_busy: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");

  cover_irq: cover property (irq);
  cover_rx_event: cover property (rx_event_request);
  cover_tx_event: cover property (tx_event_request);
endmodule : srsi_top_checker

bind srsi_top srsi_top_checker u_srsi_top_checker (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .tx_space_ready(tx_space_ready), .rx_data_ready(rx_data_ready),
  .tx_space_request(tx_space_request), .rx_data_request(rx_data_request),
  .tx_event_request(tx_event_request), .rx_event_request(rx_event_request), .irq(irq)
);

// *** verification/serial_rate_select_and_irq_tb.sv ***
// Self-checking bench for the rate and request block
module serial_rate_select_and_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn;                          // Clock, reset
  logic [7:0]  awaddr, araddr;                         // Bus addresses
  logic        awvalid, wvalid, bready, arvalid, rready;  // Master handshakes
  logic [31:0] wdata;                                  // Write data
  logic [3:0]  wstrb;                                  // Byte lanes
  wire         awready, wready, bvalid, arready, rvalid;  // Slave handshakes
  wire  [1:0]  bresp, rresp;                           // Responses
  wire  [31:0] rdata;                                  // Read data
  logic        tx_space_ready, rx_data_ready;          // Live levels
  logic [2:0]  tx_source_event;                        // Transmit source pulses
  logic [11:0] rx_source_event;                        // Receive source pulses
  wire         tx_clk_en, rx_clk_en, tx_bit_en, rx_bit_en;  // Rate enables
  wire         tx_space_request, rx_data_request, tx_event_request, rx_event_request, irq;
  int          mismatches, check_count;                // Tallies
  logic [1:0]  exp_b[$];                               // Expected write responses
  logic [33:0] exp_r[$];                               // Expected read resp and data
  int          cfg[7][5];                              // Mode, ratio, period, tx exp, rx exp
  int          r, k, s;                                // Scratch
  wire  [3:0]  pulses = {rx_bit_en, tx_bit_en, rx_clk_en, tx_clk_en};

  srsi_top u_srsi_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_space_ready(tx_space_ready), .rx_data_ready(rx_data_ready),
    .tx_source_event(tx_source_event), .rx_source_event(rx_source_event),
    .tx_clk_en(tx_clk_en), .rx_clk_en(rx_clk_en), .tx_bit_en(tx_bit_en),
    .rx_bit_en(rx_bit_en), .tx_space_request(tx_space_request),
    .rx_data_request(rx_data_request), .tx_event_request(tx_event_request),
    .rx_event_request(rx_event_request), .irq(irq)
  );

  // Compare and tally
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check

  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // A used-up bound is a hang
  task automatic wait_limit(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_limit

  // Write with both channels offered together, response taken one cycle late
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    bit ta, tw;
    int n;
    ta = 0;
    tw = 0;
    n = 0;
    exp_b.push_back(resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw) && n < 200) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    // Let the response stand one cycle unanswered so its hold is exercised
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    wait_limit(n, 200);
  endtask : axi_write

  // Read, data accepted one cycle late so the hold is exercised
  task automatic axi_read(input logic [7:0] a, input logic [33:0] want);
    int n;
    n = 0;
    exp_r.push_back(want);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    wait_limit(n, 200);
  endtask : axi_read

  // One-cycle source event, then wait until the request is due
  task automatic pulse(input bit tx, input int idx);
    @(posedge aclk);
    if (tx) tx_source_event[idx] <= 1'b1;
    else rx_source_event[idx] <= 1'b1;
    @(posedge aclk);
    tx_source_event <= '0;
    rx_source_event <= '0;
    @(posedge aclk);
    #1;
  endtask : pulse

  // Interval of the fourth pulse, so old settings have wrapped out
  task automatic measure(input int sel, input int want);
    int n;
    repeat (4) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (!pulses[sel] && n < 70000);
      wait_limit(n, 70000);
    end
    check(n, want);
  endtask : measure

  // Response watcher takes the oldest note per answer
  always @(posedge aclk) begin
    if (bvalid && bready) check(bresp, exp_b.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
  end

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, tx_space_ready, rx_data_ready} = '0;
    {tx_source_event, rx_source_event} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h5fadd19f));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped place, read-only status
    for (k = 0; k <= 'h24; k += 4) axi_read(8'(k), 34'h0);
    axi_read(8'h28, {2'h2, 32'h0});
    axi_write(8'h28, 32'h1, 2'h2);
    axi_write(8'h10, 32'hff, 2'h0);
    axi_read(8'h10, 34'h0);
    // Rate cases: mode, ratio, period, tx exponent, rx exponent
    cfg = '{'{1, 3, 0, 2, 0}, '{0, 1, 3, 1, 0}, '{0, 2, 3, 1, 0}, '{0, 3, 3, 1, 0},
            '{2, 2, 4, 0, 3}, '{0, 0, 0, 0, 0}, '{0, 0, 2, 9, 1}};
    cfg[0][2] = $urandom_range(7, 2);
    for (k = 0; k < 7; k++) begin
      axi_write(8'h00, 32'(cfg[k][2]), 2'h0);
      axi_write(8'h04, 32'(cfg[k][3]), 2'h0);
      axi_write(8'h08, 32'(cfg[k][4]), 2'h0);
      axi_write(8'h0c, 32'(cfg[k][0] | (cfg[k][1] << 6)), 2'h0);
      axi_read(8'h04, 34'(cfg[k][3]));
      axi_read(8'h08, 34'(cfg[k][4]));
      s = (cfg[k][0] == 0 && cfg[k][1] != 0) ? (8 << cfg[k][1]) : 1;
      r = (cfg[k][2] == 0) ? 256 : cfg[k][2];
      measure(0, r << cfg[k][3]);
      measure(1, r << cfg[k][4]);
      measure(2, (r << cfg[k][3]) * s);
      measure(3, (r << cfg[k][4]) * s);
    end
    // Receive source enabled and gated through
    r = $urandom_range(11, 0);
    axi_write(8'h14, 32'hc3, 2'h0);
    axi_write(8'h24, 32'h1 << r, 2'h0);
    axi_write(8'h1c, 32'h2, 2'h0);
    pulse(1'b0, r);
    check({tx_event_request, rx_event_request, irq}, 3'b011);
    axi_read(8'h20, 34'h1 << r);
    axi_read(8'h10, 34'h40);
    axi_write(8'h20, 32'h1 << r, 2'h0);
    axi_read(8'h20, 34'h0);
    // Source without its enable stays out of the summary
    pulse(1'b0, (r + 1) % 12);
    check({rx_event_request, irq}, 2'b00);
    axi_read(8'h10, 34'h0);
    axi_write(8'h20, 32'hfff, 2'h0);
    // Top-level enable off: summary still shows, request held back
    axi_write(8'h14, 32'h83, 2'h0);
    pulse(1'b0, r);
    check({rx_event_request, irq}, 2'b00);
    axi_read(8'h10, 34'h40);
    axi_write(8'h20, 32'hfff, 2'h0);
    // Transmit source event
    pulse(1'b1, 1);
    check({tx_event_request, irq}, 2'b11);
    axi_read(8'h10, 34'h80);
    axi_write(8'h18, 32'h7, 2'h0);
    // Live space and data levels, then masked
    @(posedge aclk);
    tx_space_ready <= 1'b1;
    rx_data_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    check({tx_space_request, rx_data_request, tx_event_request, irq}, 4'b1101);
    axi_read(8'h10, 34'h03);
    axi_write(8'h14, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    #1;
    check({tx_space_request, rx_data_request, irq}, 3'b000);
    complete_run();
  end
endmodule : serial_rate_select_and_irq_tb
